// File: core/spfm_pkg.sv
// Package of constants and types for the serial port flag pin multiplexer.
`default_nettype none
package spfm_pkg;
	// ------------------------------------------------------------------
	// Register map: word indices, byte address is four times the index.
	// ------------------------------------------------------------------
	localparam int          ADDR_W        = 16;
	localparam int          IDX_W         = 14;
	localparam logic [13:0] IDX_MODE_CTRL = 14'h2015;
	localparam logic [13:0] IDX_SYS_CTRL  = 14'h3FFF;
	localparam logic [13:0] IDX_SENS_CTRL = 14'h3F00;
	localparam logic [13:0] IDX_PIN_STAT  = 14'h3F01;
	localparam logic [1:0]  ALIGN_ZERO    = 2'h0;

	// ------------------------------------------------------------------
	// Register widths, fields and reset values.
	// ------------------------------------------------------------------
	localparam int          MODE_W        = 9;
	localparam int          SYS_W         = 16;
	localparam int          SENS_W        = 2;
	localparam int          BIT_ALT_CFG   = 10;
	localparam int          BIT_RX_SELECT = 4;
	localparam int          BIT_SENS_EXTERNAL_INTERRUPT_ZERO = 0;
	localparam int          BIT_SENS_EXTERNAL_INTERRUPT_ONE = 1;
	localparam logic [8:0]  MODE_RESET    = 9'h000;
	localparam logic [15:0] SYS_RESET     = 16'h0000;
	localparam logic [1:0]  SENS_RESET    = 2'h0;

	// ------------------------------------------------------------------
	// Synchronised pin vector layout and status register layout.
	// ------------------------------------------------------------------
	localparam int          PIN_N         = 5;
	localparam int          PIN_RX_FIRST  = 0;
	localparam int          PIN_RX_SECOND = 1;
	localparam int          PIN_RFS       = 2;
	localparam int          PIN_TFS       = 3;
	localparam int          PIN_SCLK      = 4;
	localparam int          STAT_REQ_LSB  = 5;
	localparam int          STAT_ALT      = 7;

	typedef enum logic [2:0] {
		SEL_MODE,
		SEL_SYS,
		SEL_SENS,
		SEL_STAT,
		SEL_NONE
	} spfm_sel_t;
endpackage
`default_nettype wire

// File: core/spfm_pin_if.sv
// Interface carrying raw pin levels to the synchroniser and clean levels back.
`timescale 1ns/1ns
`default_nettype none
interface spfm_pin_if;
	logic [spfm_pkg::PIN_N-1:0] raw;
	logic [spfm_pkg::PIN_N-1:0] clean;
	modport sync (input raw, output clean);
	modport user (output raw, input clean);
endinterface
`default_nettype wire

// File: core/spfm_pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ns
`default_nettype none
module spfm_pin_sync (
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	spfm_pin_if.sync         pins
);
	typedef struct packed {
		logic [spfm_pkg::PIN_N-1:0] s1;
		logic [spfm_pkg::PIN_N-1:0] s2;
		logic [spfm_pkg::PIN_N-1:0] s3;
		logic [spfm_pkg::PIN_N-1:0] clean;
	} spfm_sync_st_t;

	spfm_sync_st_t st_ff;
	spfm_sync_st_t nxt_st;

	// ------------------------------------------------------------------
	// Filter
	// ------------------------------------------------------------------
	// The first stage feeds only the second, so a metastable level never
	// reaches the comparison.
	always_comb begin
		nxt_st    = st_ff;
		nxt_st.s1 = pins.raw;
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		nxt_st.clean = (st_ff.s2 & st_ff.s3) |
			(st_ff.clean & (st_ff.s2 ^ st_ff.s3));
	end

	// Pins idle high, so reset to ones avoids a false falling edge.
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			st_ff <= '1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign pins.clean = st_ff.clean;
endmodule // spfm_pin_sync
`default_nettype wire

// File: core/spfm_pin_mux.sv
// Top of the serial port flag pin multiplexer with its APB registers.
//
// Implementation choice: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module spfm_pin_mux (
	input  wire logic        i_clock,
	input  wire logic        i_reset,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [15:0] i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic      [31:0] o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_receive_pin_first,
	input  wire logic        i_receive_pin_second,
	input  wire logic        i_receive_frame_sync_pin,
	output logic             o_receive_frame_sync_pin,
	output logic             o_receive_frame_sync_pin_oe,
	input  wire logic        i_transmit_frame_sync_pin,
	output logic             o_transmit_frame_sync_pin,
	output logic             o_transmit_frame_sync_pin_oe,
	output logic             o_serial_transmit_pin,
	output logic             o_serial_transmit_pin_oe,
	input  wire logic        i_serial_clock_pin,
	output logic             o_serial_clock_pin,
	output logic             o_serial_clock_pin_oe,
	input  wire logic        i_port_transmit_data,
	input  wire logic        i_port_transmit_oe,
	input  wire logic        i_port_rfs_out,
	input  wire logic        i_port_rfs_oe,
	input  wire logic        i_port_tfs_out,
	input  wire logic        i_port_tfs_oe,
	input  wire logic        i_port_sclk_out,
	input  wire logic        i_port_sclk_oe,
	output logic             o_serial_receive_input,
	output logic             o_port_rfs_in,
	output logic             o_port_tfs_in,
	output logic             o_port_sclk_in,
	input  wire logic        i_flag_output_pin,
	output logic             o_flag_input_pin,
	input  wire logic [1:0]  i_interrupt_ack,
	output logic             o_external_interrupt_zero,
	output logic             o_external_interrupt_one
);
	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [spfm_pkg::MODE_W-1:0] mode;
		logic [spfm_pkg::SYS_W-1:0]  sys;
		logic [spfm_pkg::SENS_W-1:0] sens;
		logic                        pready;
		logic                        pslverr;
		logic [31:0]                 prdata;
		logic [1:0]                  prev_fs;
		logic [1:0]                  req;
		logic                        rx_in;
		logic                        flag_in;
		logic                        rfs_in;
		logic                        tfs_in;
		logic                        sclk_in;
		logic                        dt;
		logic                        dt_oe;
		logic                        rfs_o;
		logic                        rfs_oe;
		logic                        tfs_o;
		logic                        tfs_oe;
		logic                        sclk_o;
		logic                        sclk_oe;
	} spfm_st_t;

	spfm_st_t                    st_ff;
	spfm_st_t                    nxt_st;
	spfm_pin_if                  pin_bus ();
	spfm_pkg::spfm_sel_t         sel;
	logic                        alt;
	logic                        rx_sel;
	logic [1:0]                  fs_now;
	logic [1:0]                  fall;
	logic [1:0]                  pend;

	function automatic spfm_pkg::spfm_sel_t spfm_decode(
		input logic [15:0] addr
	);
		spfm_pkg::spfm_sel_t s;
		s = spfm_pkg::SEL_NONE;
		if (addr[1:0] == spfm_pkg::ALIGN_ZERO) begin
			case (addr[15:2])
				spfm_pkg::IDX_MODE_CTRL: s = spfm_pkg::SEL_MODE;
				spfm_pkg::IDX_SYS_CTRL:  s = spfm_pkg::SEL_SYS;
				spfm_pkg::IDX_SENS_CTRL: s = spfm_pkg::SEL_SENS;
				spfm_pkg::IDX_PIN_STAT:  s = spfm_pkg::SEL_STAT;
				default:                 s = spfm_pkg::SEL_NONE;
			endcase
		end
		return s;
	endfunction

	assign pin_bus.raw[spfm_pkg::PIN_RX_FIRST]  = i_receive_pin_first;
	assign pin_bus.raw[spfm_pkg::PIN_RX_SECOND] = i_receive_pin_second;
	assign pin_bus.raw[spfm_pkg::PIN_RFS]       = i_receive_frame_sync_pin;
	assign pin_bus.raw[spfm_pkg::PIN_TFS]       = i_transmit_frame_sync_pin;
	assign pin_bus.raw[spfm_pkg::PIN_SCLK]      = i_serial_clock_pin;

	spfm_pin_sync u_sync (
		.i_clock (i_clock),
		.i_reset (i_reset),
		.pins    (pin_bus)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		sel    = spfm_decode(i_paddr);
		alt    = st_ff.sys[spfm_pkg::BIT_ALT_CFG];
		rx_sel = st_ff.mode[spfm_pkg::BIT_RX_SELECT];
		fs_now = {pin_bus.clean[spfm_pkg::PIN_TFS],
			pin_bus.clean[spfm_pkg::PIN_RFS]};
		fall   = st_ff.prev_fs & ~fs_now;

		// APB slave: one wait state, then the access completes.
		nxt_st.pready  = 1'b0;
		nxt_st.pslverr = 1'b0;
		nxt_st.prdata  = '0;
		if (i_psel && i_penable && !st_ff.pready) begin
			nxt_st.pready = 1'b1;
			case (sel)
				spfm_pkg::SEL_MODE: nxt_st.prdata[spfm_pkg::MODE_W-1:0] =
					st_ff.mode;
				spfm_pkg::SEL_SYS:  nxt_st.prdata[spfm_pkg::SYS_W-1:0] =
					st_ff.sys;
				spfm_pkg::SEL_SENS: nxt_st.prdata[spfm_pkg::SENS_W-1:0] =
					st_ff.sens;
				spfm_pkg::SEL_STAT: begin
					nxt_st.prdata[spfm_pkg::PIN_N-1:0] = pin_bus.clean;
					nxt_st.prdata[spfm_pkg::STAT_REQ_LSB +: 2] = st_ff.req;
					nxt_st.prdata[spfm_pkg::STAT_ALT] = alt;
				end
				default: nxt_st.pslverr = 1'b1;
			endcase
		end
		// Reserved bits are stored as written; software keeps them.
		if (i_psel && i_penable && st_ff.pready && i_pwrite) begin
			case (sel)
				spfm_pkg::SEL_MODE: nxt_st.mode =
					i_pwdata[spfm_pkg::MODE_W-1:0];
				spfm_pkg::SEL_SYS:  nxt_st.sys =
					i_pwdata[spfm_pkg::SYS_W-1:0];
				spfm_pkg::SEL_SENS: nxt_st.sens =
					i_pwdata[spfm_pkg::SENS_W-1:0];
				default: nxt_st.sens = st_ff.sens;
			endcase
		end

		// Receive pin choice feeds port or flag input.
		nxt_st.rx_in   = rx_sel ? pin_bus.clean[spfm_pkg::PIN_RX_SECOND] :
			pin_bus.clean[spfm_pkg::PIN_RX_FIRST];
		nxt_st.flag_in = 1'b0;
		nxt_st.sclk_in = pin_bus.clean[spfm_pkg::PIN_SCLK];
		nxt_st.sclk_o  = i_port_sclk_out;
		nxt_st.sclk_oe = i_port_sclk_oe;
		nxt_st.prev_fs = fs_now;

		// Edge mode holds a request until acknowledged; a new edge in the
		// acknowledge cycle wins. Level mode follows the low pin.
		pend = (st_ff.req & ~i_interrupt_ack) | fall;
		if (alt) begin
			nxt_st.flag_in = nxt_st.rx_in;
			nxt_st.rx_in   = 1'b1;
			nxt_st.dt      = i_flag_output_pin;
			nxt_st.dt_oe   = 1'b1;
			nxt_st.rfs_o   = 1'b0;
			nxt_st.rfs_oe  = 1'b0;
			nxt_st.tfs_o   = 1'b0;
			nxt_st.tfs_oe  = 1'b0;
			nxt_st.rfs_in  = 1'b0;
			nxt_st.tfs_in  = 1'b0;
			nxt_st.req[0]  = st_ff.sens[spfm_pkg::BIT_SENS_EXTERNAL_INTERRUPT_ZERO] ? pend[0] :
				!fs_now[0];
			nxt_st.req[1]  = st_ff.sens[spfm_pkg::BIT_SENS_EXTERNAL_INTERRUPT_ONE] ? pend[1] :
				!fs_now[1];
		end else begin
			nxt_st.dt      = i_port_transmit_data;
			nxt_st.dt_oe   = i_port_transmit_oe;
			nxt_st.rfs_o   = i_port_rfs_out;
			nxt_st.rfs_oe  = i_port_rfs_oe;
			nxt_st.tfs_o   = i_port_tfs_out;
			nxt_st.tfs_oe  = i_port_tfs_oe;
			nxt_st.rfs_in  = fs_now[0];
			nxt_st.tfs_in  = fs_now[1];
			nxt_st.req     = 2'h0;
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			st_ff         <= '0;
			st_ff.mode    <= spfm_pkg::MODE_RESET;
			st_ff.sys     <= spfm_pkg::SYS_RESET;
			st_ff.sens    <= spfm_pkg::SENS_RESET;
			st_ff.prev_fs <= 2'h3;
			st_ff.rx_in   <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_prdata                     = st_ff.prdata;
	assign o_pready                     = st_ff.pready;
	assign o_pslverr                    = st_ff.pslverr;
	assign o_receive_frame_sync_pin     = st_ff.rfs_o;
	assign o_receive_frame_sync_pin_oe  = st_ff.rfs_oe;
	assign o_transmit_frame_sync_pin    = st_ff.tfs_o;
	assign o_transmit_frame_sync_pin_oe = st_ff.tfs_oe;
	assign o_serial_transmit_pin        = st_ff.dt;
	assign o_serial_transmit_pin_oe     = st_ff.dt_oe;
	assign o_serial_clock_pin           = st_ff.sclk_o;
	assign o_serial_clock_pin_oe        = st_ff.sclk_oe;
	assign o_serial_receive_input       = st_ff.rx_in;
	assign o_port_rfs_in                = st_ff.rfs_in;
	assign o_port_tfs_in                = st_ff.tfs_in;
	assign o_port_sclk_in               = st_ff.sclk_in;
	assign o_flag_input_pin             = st_ff.flag_in;
	assign o_external_interrupt_zero    = st_ff.req[0];
	assign o_external_interrupt_one     = st_ff.req[1];
endmodule // spfm_pin_mux
`default_nettype wire

// File: tb/spfm_pin_mux_assertions.sv
// Checker of the pin multiplexer behaviour seen at its top ports.
`timescale 1ns/1ns
`default_nettype none
module spfm_pin_mux_chk (
	input wire logic        i_clock,
	input wire logic        i_reset,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [15:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        i_receive_pin_first,
	input wire logic        i_receive_pin_second,
	input wire logic        i_receive_frame_sync_pin,
	input wire logic        i_transmit_frame_sync_pin,
	input wire logic        i_serial_clock_pin,
	input wire logic        o_port_sclk_in,
	input wire logic        o_serial_transmit_pin,
	input wire logic        o_serial_transmit_pin_oe,
	input wire logic        i_flag_output_pin,
	input wire logic        o_flag_input_pin,
	input wire logic        o_serial_receive_input,
	input wire logic [1:0]  i_interrupt_ack,
	input wire logic        o_external_interrupt_zero,
	input wire logic        o_external_interrupt_one
);
	// ------------------------------------------------------------------
	// Shadow of the configuration, delayed to match the output register.
	// ------------------------------------------------------------------
	logic [3:0]  cq_ff;
	logic [3:0]  cd_ff;
	wire         wr = i_psel & i_penable & i_pwrite & o_pready & ~o_pslverr;
	wire  [13:0] ix = i_paddr[15:2];
	always_ff @(posedge i_clock) begin
		if (i_reset) begin
			cq_ff <= 4'h0;
			cd_ff <= 4'h0;
		end else begin
			cd_ff <= cq_ff;
			if (wr && ix == spfm_pkg::IDX_SYS_CTRL)
				cq_ff[0] <= i_pwdata[spfm_pkg::BIT_ALT_CFG];
			if (wr && ix == spfm_pkg::IDX_MODE_CTRL)
				cq_ff[1] <= i_pwdata[spfm_pkg::BIT_RX_SELECT];
			if (wr && ix == spfm_pkg::IDX_SENS_CTRL)
				cq_ff[3:2] <= i_pwdata[spfm_pkg::SENS_W-1:0];
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_reset);
	// Pin checks wait for six quiet cycles so the synchroniser has settled.
	chk_flag_out: assert property (
		cd_ff[0] |-> o_serial_transmit_pin_oe &&
		o_serial_transmit_pin == $past(i_flag_output_pin))
		else $error("flag out");
	chk_flag_in: assert property (
		(cd_ff[0] && $stable(i_receive_pin_first) &&
		$stable(i_receive_pin_second))[*6] |-> o_flag_input_pin ==
		(cd_ff[1] ? i_receive_pin_second : i_receive_pin_first))
		else $error("flag in");
	chk_rx_normal: assert property (
		(!cd_ff[0] && $stable(i_receive_pin_first) &&
		$stable(i_receive_pin_second))[*6] |-> !o_flag_input_pin &&
		o_serial_receive_input == (cd_ff[1] ? i_receive_pin_second :
		i_receive_pin_first))
		else $error("receive route");
	chk_sclk_pass: assert property (
		$stable(i_serial_clock_pin)[*6] |->
		o_port_sclk_in == i_serial_clock_pin)
		else $error("clock route");
	chk_external_interrupt_zero_level: assert property (
		(cd_ff[0] && !cd_ff[2] && $stable(i_receive_frame_sync_pin))[*6]
		|-> o_external_interrupt_zero == !i_receive_frame_sync_pin)
		else $error("irq zero level");
	chk_external_interrupt_one_level: assert property (
		(cd_ff[0] && !cd_ff[3] && $stable(i_transmit_frame_sync_pin))[*6]
		|-> o_external_interrupt_one == !i_transmit_frame_sync_pin)
		else $error("irq one level");
	chk_irq_hold: assert property (
		cd_ff[0] && cd_ff[2] && !i_interrupt_ack[0] &&
		o_external_interrupt_zero ##1 cd_ff[0] && cd_ff[2] |->
		o_external_interrupt_zero)
		else $error("edge request lost");
	chk_irq_off: assert property (
		!cd_ff[0] |-> !o_external_interrupt_zero &&
		!o_external_interrupt_one)
		else $error("request outside flag mode");
endmodule // spfm_pin_mux_chk
`default_nettype wire

// File: tb/spfm_pin_partner.sv
// Far-side pin drivers sharing the frame-sync and clock lines.
`timescale 1ns/1ns
`default_nettype none
module spfm_pin_partner (
	input  wire logic [4:0] i_drive,
	input  wire logic [2:0] i_dev_out,
	input  wire logic [2:0] i_dev_oe,
	output logic      [4:0] o_pin
);
	// The far side backs off a shared line while the device drives it.
	assign o_pin[1:0] = i_drive[1:0];
	assign o_pin[4:2] = (i_dev_oe & i_dev_out) | (~i_dev_oe & i_drive[4:2]);
endmodule // spfm_pin_partner
`default_nettype wire

// File: tb/spfm_pin_mux_tb_top.sv
// Self-checking bench for the serial port flag pin multiplexer.
`timescale 1ns/1ns
`default_nettype none
module spfm_pin_mux_tb_top;
	// ------------------------------------------------------------------
	// Stimulus, hookup and helpers.
	// ------------------------------------------------------------------
	localparam logic [15:0] A_MODE = {spfm_pkg::IDX_MODE_CTRL, 2'h0};
	localparam logic [15:0] A_SYS  = {spfm_pkg::IDX_SYS_CTRL, 2'h0};
	localparam logic [15:0] A_SENS = {spfm_pkg::IDX_SENS_CTRL, 2'h0};
	localparam logic [15:0] A_STAT = {spfm_pkg::IDX_PIN_STAT, 2'h0};
	logic        i_clock = 0, i_reset = 1, i_psel = 0, i_penable = 0;
	logic        i_pwrite = 0, i_flag_output_pin = 0, e;
	logic [15:0] i_paddr = 16'h0;
	logic [31:0] i_pwdata = 32'h0, o_prdata, q, v, seed = 32'h4DE3CC09;
	logic [1:0]  i_interrupt_ack = 2'h0;
	logic [7:0]  prt = 8'h0;
	logic [4:0]  drv = 5'h1F, pin, p;
	logic        o_pready, o_pslverr, o_flag_input_pin, o_port_sclk_in;
	logic        o_receive_frame_sync_pin, o_receive_frame_sync_pin_oe;
	logic        o_transmit_frame_sync_pin, o_transmit_frame_sync_pin_oe;
	logic        o_serial_transmit_pin, o_serial_transmit_pin_oe;
	logic        o_serial_clock_pin, o_serial_clock_pin_oe;
	logic        o_serial_receive_input, o_port_rfs_in, o_port_tfs_in;
	logic        o_external_interrupt_zero, o_external_interrupt_one;
	int          n_mismatch = 0, cmp_count = 0;
	logic [15:0] ra [5] = '{A_MODE, A_SYS, A_SENS, 16'h0000, A_SYS + 16'h1};
	int          wd [3] = '{9, 16, 2};
	always #10 i_clock = ~i_clock;
	spfm_pin_mux dut_u (.i_clock, .i_reset, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_receive_pin_first(pin[0]), .i_receive_pin_second(pin[1]),
		.i_receive_frame_sync_pin(pin[2]), .o_receive_frame_sync_pin,
		.o_receive_frame_sync_pin_oe, .i_transmit_frame_sync_pin(pin[3]),
		.o_transmit_frame_sync_pin, .o_transmit_frame_sync_pin_oe,
		.o_serial_transmit_pin, .o_serial_transmit_pin_oe,
		.i_serial_clock_pin(pin[4]), .o_serial_clock_pin,
		.o_serial_clock_pin_oe, .i_port_transmit_data(prt[0]),
		.i_port_transmit_oe(prt[1]), .i_port_rfs_out(prt[2]),
		.i_port_rfs_oe(prt[3]), .i_port_tfs_out(prt[4]),
		.i_port_tfs_oe(prt[5]), .i_port_sclk_out(prt[6]),
		.i_port_sclk_oe(prt[7]), .o_serial_receive_input, .o_port_rfs_in,
		.o_port_tfs_in, .o_port_sclk_in, .i_flag_output_pin,
		.o_flag_input_pin, .i_interrupt_ack, .o_external_interrupt_zero,
		.o_external_interrupt_one);
	spfm_pin_partner far_u (.i_drive(drv), .o_pin(pin),
		.i_dev_out({o_serial_clock_pin, o_transmit_frame_sync_pin,
			o_receive_frame_sync_pin}),
		.i_dev_oe({o_serial_clock_pin_oe, o_transmit_frame_sync_pin_oe,
			o_receive_frame_sync_pin_oe}));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Level on each shared pin: the device output while it drives, else ours.
	function automatic logic [4:0] pex(input logic [31:0] x);
		return {x[15] ? x[14] : x[4], x[13] ? x[12] : x[3],
			x[11] ? x[10] : x[2], x[1:0]};
	endfunction
	function automatic logic [32:0] fit(input logic [31:0] x, input int w);
		return {1'b0, x & ((32'h1 << w) - 32'h1)};
	endfunction
	task automatic cmp(input logic [32:0] g, input logic [32:0] x);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, g, x);
		end
	endtask
	task automatic wrap_up();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge i_clock);
	endtask
	task automatic apb(input logic w, input logic [15:0] a,
		input logic [31:0] d);
		int n;
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		for (n = 0; n < 9; n++) begin
			@(posedge i_clock);
			if (o_pready === 1'b1)
				break;
		end
		if (n == 9) begin
			n_mismatch++;
			$display("BAD %0t no bus answer", $time);
			wrap_up();
		end else begin
			q = o_prdata;
			e = o_pslverr;
			i_psel <= 1'b0;
			i_penable <= 1'b0;
		end
	endtask
	// ------------------------------------------------------------------
	// Main sequence.
	// ------------------------------------------------------------------
	initial begin
		wt(6);
		i_reset <= 1'b0;
		foreach (ra[k]) begin
			apb(1'b0, ra[k], 32'h0);
			cmp({e, q}, (k > 2) ? 33'h100000000 : 33'h0);
		end
		for (int k = 0; k < 12; k++) begin
			v = rnd();
			apb(1'b1, ra[k % 3], v);
			apb(1'b0, ra[k % 3], 32'h0);
			cmp({e, q}, fit(v, wd[k % 3]));
		end
		for (int s = 0; s < 2; s++) begin
			apb(1'b0, A_MODE, 32'h0);
			apb(1'b1, A_MODE, s ? (q | 32'h10) : (q & ~32'h10));
			apb(1'b1, A_SENS, 32'h0);
			apb(1'b1, A_SYS, 32'h400);
			for (int k = 0; k < 8; k++) begin
				v = rnd();
				// Frame-sync pins are never driven by the device here.
				p = pex(v & ~32'h2800);
				drv <= v[4:0];
				prt <= v[15:8];
				i_flag_output_pin <= v[16];
				// A clock pin driven by the device takes one edge more.
				wt(7);
				cmp(33'(o_flag_input_pin), 33'(s ? v[1] : v[0]));
				cmp(33'(o_serial_transmit_pin), 33'(v[16]));
				cmp(33'(o_external_interrupt_zero), 33'(!v[2]));
				cmp(33'(o_external_interrupt_one), 33'(!v[3]));
				cmp(33'(o_port_sclk_in), 33'(p[4]));
				q = {26'h0, o_serial_receive_input, o_port_rfs_in,
					o_port_tfs_in, o_receive_frame_sync_pin_oe,
					o_transmit_frame_sync_pin_oe, o_serial_transmit_pin_oe};
				cmp(33'(q), 33'h21);
				apb(1'b0, A_STAT, 32'h0);
				cmp({e, q}, 33'({1'b1, ~p[3:2], p}));
			end
		end
		apb(1'b1, A_SENS, 32'h3);
		for (int k = 0; k < 2; k++) begin
			drv[2 + k] <= 1'b1;
			wt(6);
			// Clear any request left from level mode before the real edge.
			i_interrupt_ack[k] <= 1'b1;
			wt(1);
			i_interrupt_ack[k] <= 1'b0;
			wt(2);
			v = {30'h0, o_external_interrupt_one, o_external_interrupt_zero};
			cmp(33'(v[k]), 33'h0);
			drv[2 + k] <= 1'b0;
			wt(6);
			drv[2 + k] <= 1'b1;
			wt(6);
			v = {30'h0, o_external_interrupt_one, o_external_interrupt_zero};
			cmp(33'(v[k]), 33'h1);
			i_interrupt_ack[k] <= 1'b1;
			wt(1);
			i_interrupt_ack[k] <= 1'b0;
			wt(2);
			v = {30'h0, o_external_interrupt_one, o_external_interrupt_zero};
			cmp(33'(v[k]), 33'h0);
		end
		apb(1'b1, A_SYS, 32'h0);
		wt(2);
		cmp(33'({o_external_interrupt_one, o_external_interrupt_zero}), 33'h0);
		repeat (16) begin
			v = rnd();
			p = pex(v);
			drv <= v[4:0];
			prt <= v[15:8];
			wt(7);
			cmp(33'(o_serial_receive_input), 33'(v[1]));
			cmp(33'(o_serial_transmit_pin), 33'(v[8]));
			q = {24'h0, o_serial_clock_pin_oe, o_serial_clock_pin,
				o_transmit_frame_sync_pin_oe, o_transmit_frame_sync_pin,
				o_receive_frame_sync_pin_oe, o_receive_frame_sync_pin,
				o_serial_transmit_pin_oe, o_serial_transmit_pin};
			cmp(33'(q), 33'(v[15:8]));
			q = {29'h0, o_port_sclk_in, o_port_tfs_in, o_port_rfs_in};
			cmp(33'(q), 33'(p[4:2]));
			apb(1'b0, A_STAT, 32'h0);
			cmp({e, q}, 33'(p));
		end
		wrap_up();
	end
endmodule // spfm_pin_mux_tb_top
bind spfm_pin_mux spfm_pin_mux_chk chk_u (.i_clock, .i_reset, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready, .o_pslverr,
	.i_receive_pin_first, .i_receive_pin_second, .i_receive_frame_sync_pin,
	.i_transmit_frame_sync_pin, .i_serial_clock_pin, .o_port_sclk_in,
	.o_serial_transmit_pin, .o_serial_transmit_pin_oe, .i_flag_output_pin,
	.o_flag_input_pin, .o_serial_receive_input, .i_interrupt_ack,
	.o_external_interrupt_zero, .o_external_interrupt_one);
`default_nettype wire
